// >>> dv/epi_core_model.sv
// behavioural core side: enters one routine per pending vector request
// assumes vec_req is combinational and settles before each rising edge
module epi_core_model (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ack_on,
    input  wire logic [3:0]        lat,
    input  wire epi_pkg::epi_vec_t vec_req,
    output epi_pkg::epi_vec_t      vec_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    import epi_pkg::*;

    logic [3:0] wait_reg;

    // lat cycles of pending request, then a one-cycle entry pulse;
    // lowest vector wins, and no new entry while a pulse is out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 4'h0;
            vec_ack  <= '0;
        end else begin
            vec_ack <= '0;
            if (!ack_on || vec_req == '0 || vec_ack != '0) begin
                wait_reg <= 4'h0;
            end else if (wait_reg >= lat) begin
                wait_reg <= 4'h0;
                vec_ack  <= epi_vec_t'(vec_req & (~vec_req + 5'h01));
            end else begin
                wait_reg <= wait_reg + 4'h1;
            end
        end
    end
endmodule

// >>> dv/tb_top.sv
// self-checking bench of the pin interrupt unit over apb
// assumes zero-wait apb and flags two edges after a pin change
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import epi_pkg::*;

    logic        pclk    = 1'h0;
    logic        presetn = 1'h0;
    logic        psel    = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite  = 1'h0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        ext0    = 1'h1;
    logic        ext1    = 1'h1;
    logic        gie     = 1'h0;
    logic        ack_on  = 1'h0;
    logic [3:0]  lat     = 4'h0;
    logic [23:0] pins    = 24'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        perr;
    logic        wake_req;
    epi_vec_t    vec_req;
    epi_vec_t    vec_ack;
    int          n_fail      = 0;
    int          comparisons = 0;

    // 20 MHz
    always #25 pclk = ~pclk;

    epi_top u_epi_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_line_zero(ext0),
        .ext_line_one(ext1), .change_watch_pins(pins),
        .global_int_enable(gie), .vec_ack(vec_ack), .vec_req(vec_req),
        .wake_req(wake_req));

    epi_core_model u_epi_core_model (
        .pclk(pclk), .presetn(presetn), .ack_on(ack_on), .lat(lat),
        .vec_req(vec_req), .vec_ack(vec_ack));

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // setup, then access held until pready; a hung slave counts as a miss
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        if (k == 50) n_fail++;
        rd   = prdata;
        perr = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'h0, a, 32'h0);
        chk(n, e, rd);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic drive_line(input int l, input logic v);
        @(posedge pclk);
        if (l == 0) ext0 <= v;
        else ext1 <= v;
    endtask

    // reset values, writable bits, reserved bits and an unmapped place
    task automatic s_regs;
        logic [7:0]  offs [8];
        logic [31:0] wmax [8];
        offs = '{OFF_SENSE, OFF_EXT_EN, OFF_EXT_FLAGS, OFF_GRP_EN,
                 OFF_GRP_FLAGS, OFF_MASK0, OFF_MASK1, OFF_MASK2};
        wmax = '{32'hF, 32'h3, 32'h0, 32'h7, 32'h0, 32'hFF, 32'h7F, 32'hFF};
        for (int i = 0; i < 8; i++) begin
            rdc(offs[i], 32'h0, "reset value");
            apb(1'h1, offs[i], 32'hFFFFFFFF);
            rdc(offs[i], wmax[i], "writable bits");
            apb(1'h1, offs[i], 32'h0);
        end
        apb(1'h0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, perr);
    endtask

    // each edge and change code on both lines, clear by one only
    task automatic s_edge;
        logic [31:0] b;
        logic [31:0] e;
        @(posedge pclk);
        gie <= 1'h1;
        for (int l = 0; l < 2; l++) begin
            for (int m = 1; m < 4; m++) begin
                b = 32'h1 << l;
                apb(1'h1, OFF_SENSE, 32'(m) << (2 * l));
                apb(1'h1, OFF_EXT_EN, b);
                drive_line(l, 1'h0);
                tick(3);
                e = (m != 3) ? b : 32'h0;
                chk("edge req", e, vec_req);
                rdc(OFF_EXT_FLAGS, e, "fall flag");
                apb(1'h1, OFF_EXT_FLAGS, 32'h0);
                rdc(OFF_EXT_FLAGS, e, "flag kept");
                apb(1'h1, OFF_EXT_FLAGS, b);
                rdc(OFF_EXT_FLAGS, 32'h0, "flag cleared");
                drive_line(l, 1'h1);
                tick(3);
                e = (m != 2) ? b : 32'h0;
                rdc(OFF_EXT_FLAGS, e, "rise flag");
                @(posedge pclk);
                gie <= 1'h0;
                tick(1);
                chk("gated req", 32'h0, vec_req);
                @(posedge pclk);
                gie <= 1'h1;
                apb(1'h1, OFF_EXT_FLAGS, b);
            end
        end
    endtask

    // level sense: request follows the pin, flag forced clear
    task automatic s_level;
        logic [31:0] b;
        for (int l = 0; l < 2; l++) begin
            b = 32'h1 << l;
            apb(1'h1, OFF_SENSE, 32'(SENSE_RISE) << (2 * l));
            apb(1'h1, OFF_EXT_EN, b);
            drive_line(l, 1'h0);
            tick(1);
            drive_line(l, 1'h1);
            tick(3);
            rdc(OFF_EXT_FLAGS, b, "rise flag");
            apb(1'h1, OFF_SENSE, 32'h0);
            rdc(OFF_EXT_FLAGS, 32'h0, "level flag");
            drive_line(l, 1'h0);
            tick(1);
            chk("level req", b, vec_req);
            chk("level wake", 32'h1, wake_req);
            rdc(OFF_EXT_FLAGS, 32'h0, "level flag low");
            @(posedge pclk);
            gie <= 1'h0;
            tick(1);
            chk("gated level", 32'h0, vec_req);
            @(posedge pclk);
            gie <= 1'h1;
            drive_line(l, 1'h1);
            tick(1);
            chk("level gone", 32'h0, vec_req);
        end
        apb(1'h1, OFF_EXT_EN, 32'h0);
    endtask

    // top pin of each group masked in, bottom pin masked out
    task automatic s_groups;
        int tp;
        for (int g = 0; g < 3; g++) begin
            tp = (g == 1) ? 14 : 8 * g + 7;
            apb(1'h1, OFF_MASK0 + 8'(4 * g), 32'h1 << (tp - 8 * g));
            apb(1'h1, OFF_GRP_EN, 32'h1 << g);
            @(posedge pclk);
            pins[8 * g] <= ~pins[8 * g];
            tick(3);
            rdc(OFF_GRP_FLAGS, 32'h0, "masked out");
            @(posedge pclk);
            pins[tp] <= ~pins[tp];
            #1;
            chk("wake", 32'h1, wake_req);
            tick(3);
            chk("group req", 32'h4 << g, vec_req);
            rdc(OFF_GRP_FLAGS, 32'h1 << g, "group flag");
            apb(1'h1, OFF_GRP_EN, 32'h0);
            tick(1);
            chk("group off", 32'h0, vec_req);
            rdc(OFF_GRP_FLAGS, 32'h1 << g, "flag sticky");
            apb(1'h1, OFF_GRP_FLAGS, 32'h0);
            rdc(OFF_GRP_FLAGS, 32'h1 << g, "zero kept");
            apb(1'h1, OFF_GRP_FLAGS, 32'h1 << g);
            rdc(OFF_GRP_FLAGS, 32'h0, "group clear");
            apb(1'h1, OFF_MASK0 + 8'(4 * g), 32'h0);
        end
    endtask

    // core entry clears the flag, prompt and slow entry
    task automatic s_ack;
        int k;
        apb(1'h1, OFF_SENSE, 32'(SENSE_ANY));
        apb(1'h1, OFF_EXT_EN, 32'h1);
        for (int i = 0; i < 2; i++) begin
            k = 0;
            @(posedge pclk);
            ack_on <= 1'h1;
            lat    <= 4'(3 * i);
            ext0   <= ~ext0;
            while (vec_ack === 5'h00 && k < 20) begin
                tick(1);
                k++;
            end
            chk("entry", 32'h1, vec_ack);
            tick(2);
            chk("entered req", 32'h0, vec_req);
            rdc(OFF_EXT_FLAGS, 32'h0, "entered flag");
        end
        @(posedge pclk);
        ack_on <= 1'h0;
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        s_regs();
        s_edge();
        s_level();
        s_groups();
        s_ack();
        end_sim();
    end

    // about 550 cycles expected; cut off well beyond
    initial begin
        #1000000;
        n_fail++;
        end_sim();
    end
endmodule

// >>> hw/epi_pkg.sv
// constants and carrier types of the external pin interrupt unit
// assumes a 32-bit APB register bus and a 5-vector interrupt core
package epi_pkg;

    // bus geometry
    localparam int          APB_AW        = 8;
    localparam int          APB_DW        = 32;

    // register byte offsets
    localparam logic [7:0]  OFF_SENSE     = 8'h00;
    localparam logic [7:0]  OFF_EXT_EN    = 8'h04;
    localparam logic [7:0]  OFF_EXT_FLAGS = 8'h08;
    localparam logic [7:0]  OFF_GRP_EN    = 8'h0C;
    localparam logic [7:0]  OFF_GRP_FLAGS = 8'h10;
    localparam logic [7:0]  OFF_MASK0     = 8'h14;
    localparam logic [7:0]  OFF_MASK1     = 8'h18;
    localparam logic [7:0]  OFF_MASK2     = 8'h1C;

    // field layout
    localparam int          EXT_LINES     = 2;
    localparam int          GROUPS        = 3;
    localparam int          GRP_PINS      = 8;
    localparam int          SENSE_W       = 2;
    localparam int          SENSE_ZERO_LSB = 0;
    localparam int          SENSE_ONE_LSB = 2;

    // pin 15 has no pin behind it; its mask bit stays zero
    localparam logic [23:0] PIN_PRESENT   = 24'hFF7FFF;

    // reset values
    localparam logic [3:0]  RST_SENSE     = 4'h0;
    localparam logic [1:0]  RST_EXT_EN    = 2'h0;
    localparam logic [1:0]  RST_EXT_FLAGS = 2'h0;
    localparam logic [2:0]  RST_GRP_EN    = 3'h0;
    localparam logic [2:0]  RST_GRP_FLAGS = 3'h0;
    localparam logic [7:0]  RST_MASK      = 8'h00;

    // sense codes
    localparam logic [1:0]  SENSE_LOW     = 2'h0;
    localparam logic [1:0]  SENSE_ANY     = 2'h1;
    localparam logic [1:0]  SENSE_FALL    = 2'h2;
    localparam logic [1:0]  SENSE_RISE    = 2'h3;

    // one bit per vector, ext0 in bit 0
    typedef struct packed {
        logic grp2;
        logic grp1;
        logic grp0;
        logic ext1;
        logic ext0;
    } epi_vec_t;

endpackage

// >>> hw/epi_sense_detect.sv
// sense decoder for one external interrupt line
// assumes smp and prev are consecutive pclk samples of the pin
module epi_sense_detect (
    input  wire logic [1:0] mode,
    input  wire logic       pin_raw,
    input  wire logic       smp,
    input  wire logic       prev,
    output logic            edge_event,
    output logic            level_active
);
    import epi_pkg::*;

    // edges come only from sampled values, so glitches shorter
    // than a clock period may be missed
    always_comb begin
        edge_event   = 1'b0;
        level_active = 1'b0;
        unique case (mode)
            SENSE_LOW: begin
                level_active = ~pin_raw;
            end
            SENSE_ANY: begin
                edge_event = smp ^ prev;
            end
            SENSE_FALL: begin
                edge_event = prev & ~smp;
            end
            SENSE_RISE: begin
                edge_event = smp & ~prev;
            end
        endcase
    end

endmodule

// >>> hw/epi_top.sv
// external pin and pin-change interrupt unit with an APB register slave
// assumes pins are synchronous to pclk; the core supplies its global
// enable bit and one acknowledge pulse per vector on routine entry
//
// Added by the designer: the APB interface to the registers and the register offsets.

// Behaviour
// - line one sense: low, change, fall, rise
// - line zero sense uses same four codes
// - sample pins on clock, compare for edges
// - pulses over one clock always caught
// - line request needs enable and global enable
// - pins driven as outputs still interrupt
// - qualifying edge sets line's sticky flag
// - level mode keeps line flag cleared
// - routine entry clears matching flag
// - writing one clears flag, zero ignored
// - five separate vector request outputs
// - group two watches pins 23 to 16
// - group one watches pins 14 to 8
// - group zero watches pins 7 to 0
// - masked pin change sets group flag
// - unused register bits read as zero
// - flag, group enable, global enable request
// - pin change wake works without clock
// - low level asynchronous, edges need clock
// - cleared mask bit blocks that pin
module epi_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [epi_pkg::APB_AW-1:0] paddr,
    input  wire logic [epi_pkg::APB_DW-1:0] pwdata,
    output logic      [epi_pkg::APB_DW-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       ext_line_zero,
    input  wire logic                       ext_line_one,
    input  wire logic [23:0]                change_watch_pins,
    input  wire logic                       global_int_enable,
    input  wire epi_pkg::epi_vec_t          vec_ack,
    output epi_pkg::epi_vec_t               vec_req,
    output logic                            wake_req
);
    import epi_pkg::*;

    // software-visible state
    logic [3:0]        sense_reg;
    logic [1:0]        ext_en_reg;
    logic [1:0]        ext_flag_reg;
    logic [1:0]        ext_flag_next;
    logic [2:0]        grp_en_reg;
    logic [2:0]        grp_flag_reg;
    logic [2:0]        grp_flag_next;
    logic [7:0]        mask_reg [GROUPS];
    logic [31:0]       prdata_reg;

    // pin samples
    logic [1:0]        ext_raw;
    logic [1:0]        ext_smp_reg;
    logic [1:0]        ext_prev_reg;
    logic [23:0]       pc_smp_reg;
    logic [23:0]       pc_prev_reg;

    // decoded events
    logic [1:0]        ext_event;
    logic [1:0]        ext_level;
    logic [1:0]        ext_is_level;
    logic [23:0]       mask_flat;
    logic [23:0]       grp_en_flat;
    logic [23:0]       pc_change;
    logic [2:0]        grp_hit;
    logic [4:0]        ack_bits;
    logic [4:0]        req_bits;

    // bus decode
    logic              wr_en;
    logic              setup_rd;
    logic              addr_hit;
    logic [31:0]       rd_word;

    assign ext_raw  = {ext_line_one, ext_line_zero};
    assign ack_bits = vec_ack;

    // ---------------- APB slave ----------------

    // zero wait states: every access completes in its first access cycle
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_hit;
    assign wr_en    = psel & penable & pwrite & addr_hit;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign prdata   = prdata_reg;

    // read mux; bits with no storage stay zero
    always_comb begin
        rd_word  = '0;
        addr_hit = 1'b1;
        case (paddr)
            OFF_SENSE:     rd_word[3:0] = sense_reg;
            OFF_EXT_EN:    rd_word[1:0] = ext_en_reg;
            OFF_EXT_FLAGS: rd_word[1:0] = ext_flag_reg;
            OFF_GRP_EN:    rd_word[2:0] = grp_en_reg;
            OFF_GRP_FLAGS: rd_word[2:0] = grp_flag_reg;
            OFF_MASK0:     rd_word[7:0] = mask_reg[0];
            OFF_MASK1:     rd_word[7:0] = mask_reg[1];
            OFF_MASK2:     rd_word[7:0] = mask_reg[2];
            default:       addr_hit     = 1'b0;
        endcase
    end

    // read data captured in the setup cycle so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_reg <= rd_word;
        end
    end

    // control registers; unused upper bits are simply not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_reg  <= RST_SENSE;
            ext_en_reg <= RST_EXT_EN;
            grp_en_reg <= RST_GRP_EN;
        end else if (wr_en) begin
            if (paddr == OFF_SENSE) begin
                sense_reg <= pwdata[3:0];
            end
            if (paddr == OFF_EXT_EN) begin
                ext_en_reg <= pwdata[1:0];
            end
            if (paddr == OFF_GRP_EN) begin
                grp_en_reg <= pwdata[2:0];
            end
        end
    end

    // per-pin mask registers; absent pin 15 cannot be enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int g = 0; g < GROUPS; g++) begin
                mask_reg[g] <= RST_MASK;
            end
        end else if (wr_en) begin
            for (int g = 0; g < GROUPS; g++) begin
                if (paddr == OFF_MASK0 + 8'(4 * g)) begin
                    mask_reg[g] <= pwdata[7:0] & PIN_PRESENT[g*8 +: 8];
                end
            end
        end
    end

    // ---------------- external lines ----------------

    // no direction gating: a pin driven as output still triggers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_smp_reg  <= 2'h0;
            ext_prev_reg <= 2'h0;
        end else begin
            ext_smp_reg  <= ext_raw;
            ext_prev_reg <= ext_smp_reg;
        end
    end

    // one decoder per line; line one uses bits 3:2, line zero 1:0
    for (genvar i = 0; i < EXT_LINES; i++) begin : g_line
        logic [1:0] mode;
        assign mode = sense_reg[i*SENSE_W +: SENSE_W];
        assign ext_is_level[i] = (mode == SENSE_LOW);
        epi_sense_detect u_sense (
            .mode         (mode),
            .pin_raw      (ext_raw[i]),
            .smp          (ext_smp_reg[i]),
            .prev         (ext_prev_reg[i]),
            .edge_event   (ext_event[i]),
            .level_active (ext_level[i])
        );
    end

    // set wins over both clears; level mode forces the flag low
    always_comb begin
        for (int i = 0; i < EXT_LINES; i++) begin
            if (ext_is_level[i]) begin
                ext_flag_next[i] = 1'b0;
            end else begin
                ext_flag_next[i] = (ext_flag_reg[i]
                    & ~(wr_en && paddr == OFF_EXT_FLAGS && pwdata[i])
                    & ~ack_bits[i])
                    | ext_event[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_flag_reg <= RST_EXT_FLAGS;
        end else begin
            ext_flag_reg <= ext_flag_next;
        end
    end

    // ---------------- pin-change groups ----------------

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_smp_reg  <= 24'h000000;
            pc_prev_reg <= 24'h000000;
        end else begin
            pc_smp_reg  <= change_watch_pins;
            pc_prev_reg <= pc_smp_reg;
        end
    end

    // flatten masks and group enables to one bit per pin
    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
        assign mask_flat[g*GRP_PINS +: GRP_PINS]   = mask_reg[g];
        assign grp_en_flat[g*GRP_PINS +: GRP_PINS] = {GRP_PINS{grp_en_reg[g]}};
        assign grp_hit[g] = |pc_change[g*GRP_PINS +: GRP_PINS];
    end

    // masked pins only; pin 15 never contributes
    assign pc_change = (pc_smp_reg ^ pc_prev_reg) & mask_flat & PIN_PRESENT;

    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            grp_flag_next[g] = (grp_flag_reg[g]
                & ~(wr_en && paddr == OFF_GRP_FLAGS && pwdata[g])
                & ~ack_bits[EXT_LINES + g])
                | grp_hit[g];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_flag_reg <= RST_GRP_FLAGS;
        end else begin
            grp_flag_reg <= grp_flag_next;
        end
    end

    // ---------------- requests toward the core ----------------

    // level requests follow the raw pin with no flop in the path
    always_comb begin
        for (int i = 0; i < EXT_LINES; i++) begin
            req_bits[i] = global_int_enable & ext_en_reg[i]
                & (ext_is_level[i] ? ext_level[i] : ext_flag_reg[i]);
        end
        for (int g = 0; g < GROUPS; g++) begin
            req_bits[EXT_LINES + g] = global_int_enable
                & grp_en_reg[g] & grp_flag_reg[g];
        end
    end

    assign vec_req = req_bits;

    // wake needs no clock edge: live pins against the held sample;
    // edge modes on the ext lines cannot wake, since they need pclk
    assign wake_req = |((change_watch_pins ^ pc_smp_reg) & mask_flat
                        & grp_en_flat & PIN_PRESENT)
                    | |(ext_level & ext_is_level & ext_en_reg);

    // ---------------- checks ----------------

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_rise_sets_flag: assert property (
        $rose(ext_smp_reg[1]) && sense_reg[3:2] == SENSE_RISE |=> ext_flag_reg[1])
    else $error("rising edge on line one did not set its flag");

    a_fall_sets_flag: assert property (
        $fell(ext_smp_reg[0]) && sense_reg[1:0] == SENSE_FALL |=> ext_flag_reg[0])
    else $error("falling edge on line zero did not set its flag");

    a_pulse_caught: assert property (
        sense_reg[1:0] == SENSE_ANY && !ext_line_zero ##1 ext_line_zero
        |-> ##2 ext_flag_reg[0])
    else $error("two-cycle pulse on line zero was missed");

    a_level_no_flag: assert property (
        sense_reg[3:2] == SENSE_LOW |=> !ext_flag_reg[1])
    else $error("line one flag set while in level mode");

    a_level_req: assert property (
        global_int_enable && ext_en_reg[0] && sense_reg[1:0] == SENSE_LOW
        && !ext_line_zero |-> vec_req.ext0)
    else $error("low level on line zero gave no request");

    a_gie_blocks: assert property (
        !global_int_enable |-> vec_req == '0)
    else $error("request raised with global enable clear");

    a_ack_clears: assert property (
        vec_ack.ext0 && !ext_event[0] |=> !ext_flag_reg[0])
    else $error("acknowledge did not clear line zero flag");

    a_write_one: assert property (
        wr_en && paddr == OFF_EXT_FLAGS && pwdata[1] && !ext_event[1]
        |=> !ext_flag_reg[1])
    else $error("write of one did not clear line one flag");

    a_write_zero: assert property (
        wr_en && paddr == OFF_GRP_FLAGS && pwdata[2:0] == 3'h0
        && !vec_ack.grp2 |=> grp_flag_reg[2] >= $past(grp_flag_reg[2]))
    else $error("write of zero cleared group two flag");

    a_group_sets: assert property (
        mask_reg[2][7] && $changed(pc_smp_reg[23]) |=> grp_flag_reg[2])
    else $error("masked change on pin 23 did not set group two flag");

    a_mask_blocks: assert property (
        mask_reg[0] == 8'h00 && !grp_flag_reg[0] && !$changed(mask_reg[0])
        |=> !grp_flag_reg[0])
    else $error("group zero flag set with all its pins masked");

    a_reserved_zero: assert property (
        psel && penable && !pwrite && paddr == OFF_SENSE
        |-> prdata[31:4] == '0 && pready)
    else $error("reserved bits of sense register read nonzero");

    a_any_sets_flag: assert property (
        $changed(ext_smp_reg[1]) && sense_reg[3:2] == SENSE_ANY |=> ext_flag_reg[1])
    else $error("change on line one did not set its flag");

    a_line_gated: assert property (
        !ext_en_reg[1] || !global_int_enable |-> !vec_req.ext1)
    else $error("line one request raised while disabled");

    a_pin15_absent: assert property (
        mask_reg[1][7] == 1'b0)
    else $error("mask bit of absent pin 15 was set");

    a_level_wake: assert property (
        ext_en_reg[0] && sense_reg[1:0] == SENSE_LOW && !ext_line_zero |-> wake_req)
    else $error("low level on line zero gave no wake");

    a_grp_write_one: assert property (
        wr_en && paddr == OFF_GRP_FLAGS && pwdata[0] && !grp_hit[0]
        |=> !grp_flag_reg[0])
    else $error("write of one did not clear group zero flag");

endmodule
